// ===== l2fa_core.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module l2fa_core #(
  parameter int SEC_CYCLES = l2fa_pkg::SEC_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire l2fa_pkg::l2fa_frame_s frame_i,
  output l2fa_pkg::l2fa_dec_s dec_o
);
  typedef enum logic {ST_IDLE, ST_SCAN} l2fa_scan_e;

  logic [11:0] pgt [l2fa_pkg::PGT_N];
  logic [11:0] flood [l2fa_pkg::NFLOOD];
  logic [7:0] pcfg [l2fa_pkg::NPORT];
  l2fa_pkg::l2fa_entry_s tbl [l2fa_pkg::MAC_N];
  logic [19:0] age_interval;
  logic [47:0] acc_mac;
  logic [11:0] acc_vid;
  logic [11:0] acc_dest;
  logic acc_direct;
  logic [15:0] storm_limit;
  logic [3:0] filt_port;
  logic filt_port_en;
  logic [11:0] filt_vid;
  logic filt_vid_en;
  l2fa_scan_e state;
  logic [3:0] scan_idx;
  logic age_pend;
  logic [27:0] div_cnt;
  logic sec_tick;
  logic [19:0] age_sec;
  logic auto_due;

  // Lowest matching index; entries are unique per address and VID
  function automatic logic [4:0] find(input logic [47:0] mac, input logic [11:0] vid);
    logic [4:0] r;
    r = 5'h00;
    for (int i = l2fa_pkg::MAC_N - 1; i >= 0; i--) begin
      if (tbl[i].valid && tbl[i].mac == mac && tbl[i].vid == vid) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] pc_src_clip(input logic [3:0] p);
    return (p < 4'(l2fa_pkg::NPORT)) ? p : 4'(l2fa_pkg::CPU_PORT);
  endfunction

  // Register decode
  logic apb_acc;
  logic apb_wr;
  logic [11:0] pgt_off;
  logic [11:0] fl_off;
  logic [11:0] pc_off;
  logic [6:0] pgt_idx;
  logic [2:0] fl_idx;
  logic [3:0] pc_idx;
  logic in_pgt;
  logic in_fl;
  logic in_pc;
  logic rd_hit;
  logic [31:0] rd_data;

  assign apb_acc = psel_i && penable_i;
  assign apb_wr = apb_acc && pwrite_i && pready_o && rd_hit;
  assign pgt_off = paddr_i - l2fa_pkg::OFF_PGT;
  assign fl_off = paddr_i - l2fa_pkg::OFF_FLOOD;
  assign pc_off = paddr_i - l2fa_pkg::OFF_PCFG;
  assign pgt_idx = pgt_off[8:2];
  assign fl_idx = fl_off[4:2];
  assign pc_idx = pc_off[5:2];
  assign in_pgt = paddr_i >= l2fa_pkg::OFF_PGT && paddr_i < l2fa_pkg::OFF_PGT_END;
  assign in_fl = paddr_i >= l2fa_pkg::OFF_FLOOD && paddr_i < l2fa_pkg::OFF_FLOOD_END;
  assign in_pc = paddr_i >= l2fa_pkg::OFF_PCFG && paddr_i < l2fa_pkg::OFF_PCFG_END;

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr_i[1:0] != 2'b00) begin
      rd_hit = 1'b0;
    end else if (in_pgt) begin
      rd_data = {20'h00000, pgt[pgt_idx]};
    end else if (in_fl) begin
      rd_data = {20'h00000, flood[fl_idx]};
    end else if (in_pc) begin
      rd_data = {24'h000000, pcfg[pc_idx]};
    end else begin
      case (paddr_i)
        l2fa_pkg::OFF_AGE_INT: rd_data = {12'h000, age_interval};
        l2fa_pkg::OFF_MAC_LO: rd_data = acc_mac[31:0];
        l2fa_pkg::OFF_MAC_HI: rd_data = {4'h0, acc_vid, acc_mac[47:32]};
        l2fa_pkg::OFF_MAC_ACC: rd_data = {state == ST_SCAN, 18'h00000, acc_direct, acc_dest};
        l2fa_pkg::OFF_AGE_FILT: begin
          rd_data = {3'h0, filt_vid_en, filt_vid, 11'h000, filt_port_en, filt_port};
        end
        l2fa_pkg::OFF_STORM: rd_data = {16'h0000, storm_limit};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_acc && !pready_o;
      prdata_o <= (apb_acc && !pready_o && rd_hit && !pwrite_i) ? rd_data : 32'h0000_0000;
      pslverr_o <= apb_acc && !pready_o && !rd_hit;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age_interval <= l2fa_pkg::AGE_INT_RESET;
      acc_mac <= 48'h0000_0000_0000;
      acc_vid <= 12'h000;
      acc_dest <= 12'h000;
      acc_direct <= 1'b0;
      storm_limit <= l2fa_pkg::STORM_RESET;
      filt_port <= 4'h0;
      filt_port_en <= 1'b0;
      filt_vid <= 12'h000;
      filt_vid_en <= 1'b0;
    end else if (apb_wr) begin
      case (paddr_i)
        l2fa_pkg::OFF_AGE_INT: age_interval <= pwdata_i[19:0];
        l2fa_pkg::OFF_MAC_LO: acc_mac[31:0] <= pwdata_i;
        l2fa_pkg::OFF_MAC_HI: begin
          acc_mac[47:32] <= pwdata_i[15:0];
          acc_vid <= pwdata_i[27:16];
        end
        l2fa_pkg::OFF_MAC_ACC: begin
          acc_dest <= pwdata_i[11:0];
          acc_direct <= pwdata_i[l2fa_pkg::ACC_DIRECT];
        end
        l2fa_pkg::OFF_AGE_FILT: begin
          filt_port <= pwdata_i[3:0];
          filt_port_en <= pwdata_i[l2fa_pkg::FILT_PORT_EN];
          filt_vid <= pwdata_i[l2fa_pkg::FILT_VID +: 12];
          filt_vid_en <= pwdata_i[l2fa_pkg::FILT_VID_EN];
        end
        l2fa_pkg::OFF_STORM: storm_limit <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < l2fa_pkg::NFLOOD; i++) begin
        flood[i] <= l2fa_pkg::ALL_PORTS;
      end
      for (int i = 0; i < l2fa_pkg::NPORT; i++) begin
        pcfg[i] <= l2fa_pkg::PCFG_RESET;
      end
    end else if (apb_wr && in_fl) begin
      flood[fl_idx] <= pwdata_i[11:0];
    end else if (apb_wr && in_pc) begin
      pcfg[pc_idx] <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < l2fa_pkg::PGT_N; i++) begin
        if (i < l2fa_pkg::PGT_UC_N) begin
          pgt[i] <= l2fa_pkg::ONE_PORT << i;
        end else if (i < l2fa_pkg::PGT_AGGR) begin
          pgt[i] <= 12'h000;
        end else if (i < l2fa_pkg::PGT_SRC) begin
          pgt[i] <= l2fa_pkg::ALL_PORTS;
        end else begin
          pgt[i] <= ~(l2fa_pkg::ONE_PORT << (i - l2fa_pkg::PGT_SRC));
        end
      end
    end else if (apb_wr && in_pgt && pgt_idx >= 7'(l2fa_pkg::PGT_UC_N)) begin
      pgt[pgt_idx] <= pwdata_i[11:0];
    end
  end

  // Command interface
  l2fa_pkg::l2fa_cmd_e cmd;
  logic cmd_go;
  logic cmd_age_go;
  logic cpu_learn_go;
  logic cpu_entry_remove_cmd_go;
  logic [4:0] cpu_res;
  logic [3:0] cpu_tgt;
  logic [3:0] free_idx;
  logic free_ok;
  logic scan_go;

  assign cmd = l2fa_pkg::l2fa_cmd_e'(pwdata_i[l2fa_pkg::ACC_CMD +: 2]);
  assign cmd_go = apb_wr && paddr_i == l2fa_pkg::OFF_MAC_ACC && state == ST_IDLE;
  assign cmd_age_go = cmd_go && cmd == l2fa_pkg::CMD_AGE;
  assign cpu_tgt = cpu_res[4] ? cpu_res[3:0] : free_idx;
  assign cpu_learn_go = cmd_go && cmd == l2fa_pkg::CMD_LEARN && (cpu_res[4] || free_ok);
  assign cpu_entry_remove_cmd_go = cmd_go && cmd == l2fa_pkg::CMD_ENTRY_REMOVE_CMD && cpu_res[4];
  assign scan_go = state == ST_IDLE && (cmd_age_go || age_pend);

  always_comb begin
    free_idx = 4'h0;
    free_ok = 1'b0;
    for (int i = l2fa_pkg::MAC_N - 1; i >= 0; i--) begin
      if (!tbl[i].valid) begin
        free_idx = 4'(i);
        free_ok = 1'b1;
      end
    end
  end

  // Frame path
  l2fa_pkg::l2fa_frame_s fr;
  logic [7:0] pc;
  logic [4:0] s_res;
  logic [4:0] d_res;
  logic rx_ok;
  logic s_same;
  logic lrn;
  logic hw_learn;
  logic hw_ins;
  logic lrn_copy;
  logic lrn_redir;
  logic lrn_discard;
  logic age_clr;
  logic grant;
  logic known;
  logic [11:0] base;
  logic [11:0] fwd;
  logic [11:0] next_dest;

  assign fr = frame_i;
  assign pc = (fr.src_port < 4'(l2fa_pkg::NPORT)) ? pcfg[fr.src_port] : 8'h00;
  // In a process so that table updates re-run the lookups, not only key changes
  always_comb begin
    cpu_res = find(acc_mac, acc_vid);
    s_res = find(fr.smac, fr.vid);
    d_res = find(fr.dmac, fr.vid);
  end
  assign rx_ok = fr.valid && pc[l2fa_pkg::PCFG_RECV];
  assign s_same = s_res[4] && tbl[s_res[3:0]].port == fr.src_port;
  assign lrn = rx_ok && pc[l2fa_pkg::PCFG_LEARN] && !s_same;
  assign hw_learn = lrn && pc[l2fa_pkg::PCFG_AUTO] && !pc[l2fa_pkg::PCFG_CPU]
                    && !pc[l2fa_pkg::PCFG_DROP];
  // CPU command owns the free slot in its cycle; the frame is learned on its next repeat
  assign hw_ins = hw_learn && !s_res[4] && free_ok && !cmd_go;
  assign lrn_copy = lrn && pc[l2fa_pkg::PCFG_CPU] && !pc[l2fa_pkg::PCFG_DROP];
  assign lrn_redir = lrn && pc[l2fa_pkg::PCFG_CPU] && pc[l2fa_pkg::PCFG_DROP];
  assign lrn_discard = lrn && !pc[l2fa_pkg::PCFG_CPU] && pc[l2fa_pkg::PCFG_DROP];
  assign age_clr = rx_ok && s_same;
  assign known = d_res[4] && fr.dmac != l2fa_pkg::BCAST_MAC;

  l2fa_policer u_policer (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .sec_tick_i(sec_tick),
    .limit_i(storm_limit),
    .req_i(lrn && pc[l2fa_pkg::PCFG_CPU]),
    .grant_o(grant)
  );

  always_comb begin
    if (fr.dmac == l2fa_pkg::BCAST_MAC) begin
      base = flood[int'(l2fa_pkg::FT_BC)];
    end else if (!known) begin
      base = flood[int'(fr.ftype)];
    end else if (tbl[d_res[3:0]].direct) begin
      base = tbl[d_res[3:0]].dest;
    end else begin
      base = pgt[tbl[d_res[3:0]].dest[5:0]];
    end
    fwd = base & pgt[l2fa_pkg::PGT_AGGR + int'(fr.aggr_hash)]
          & pgt[l2fa_pkg::PGT_SRC + int'(pc_src_clip(fr.src_port))];
    if (!rx_ok || lrn_discard) begin
      next_dest = 12'h000;
    end else if (lrn_redir) begin
      next_dest = grant ? l2fa_pkg::CPU_BIT : 12'h000;
    end else if (lrn_copy && grant) begin
      next_dest = fwd | l2fa_pkg::CPU_BIT;
    end else begin
      next_dest = fwd;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dec_o <= '0;
    end else begin
      dec_o.valid <= fr.valid;
      dec_o.dest_mask <= next_dest;
      dec_o.to_cpu <= next_dest[l2fa_pkg::CPU_PORT];
      dec_o.cpu_queue <= (lrn_copy || lrn_redir) ? pc[l2fa_pkg::PCFG_CPUQ +: 3] : 3'h0;
    end
  end

  // Age timing
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= 28'h0000000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= div_cnt == 28'(SEC_CYCLES - 1);
      div_cnt <= (div_cnt == 28'(SEC_CYCLES - 1)) ? 28'h0000000 : div_cnt + 28'h0000001;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age_sec <= 20'h00000;
      auto_due <= 1'b0;
    end else begin
      auto_due <= 1'b0;
      if (age_interval == 20'h00000) begin
        age_sec <= 20'h00000;
      end else if (sec_tick) begin
        if (age_sec + 20'h00001 >= age_interval) begin
          age_sec <= 20'h00000;
          auto_due <= 1'b1;
        end else begin
          age_sec <= age_sec + 20'h00001;
        end
      end
    end
  end

  // A due scan that meets a busy engine waits instead of being lost
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age_pend <= 1'b0;
    end else if (auto_due) begin
      age_pend <= 1'b1;
    end else if (scan_go) begin
      age_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      scan_idx <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (scan_go) begin
            state <= ST_SCAN;
            scan_idx <= 4'h0;
          end
        end
        ST_SCAN: begin
          scan_idx <= scan_idx + 4'h1;
          if (scan_idx == 4'hF) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  logic scan_match;
  assign scan_match = state == ST_SCAN && tbl[scan_idx].valid
                      && (!filt_port_en || tbl[scan_idx].port == filt_port)
                      && (!filt_vid_en || tbl[scan_idx].vid == filt_vid);

  // Later updates win; a source hit keeps an entry the scan would drop
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < l2fa_pkg::MAC_N; i++) begin
        tbl[i] <= '0;
      end
    end else begin
      for (int i = 0; i < l2fa_pkg::MAC_N; i++) begin
        if (scan_match && scan_idx == 4'(i)) begin
          if (tbl[i].age) begin
            tbl[i].valid <= 1'b0;
          end else begin
            tbl[i].age <= 1'b1;
          end
        end
        if (age_clr && s_res[3:0] == 4'(i)) begin
          tbl[i].age <= 1'b0;
          tbl[i].valid <= 1'b1;
        end
        if (hw_learn && s_res[4] && s_res[3:0] == 4'(i)) begin
          tbl[i].port <= fr.src_port;
          tbl[i].dest <= {8'h00, fr.src_port};
          tbl[i].age <= 1'b0;
        end
        if (hw_ins && free_idx == 4'(i)) begin
          tbl[i] <= {3'b100, fr.smac, fr.vid, 8'h00, fr.src_port, fr.src_port};
        end
        if (cpu_learn_go && cpu_tgt == 4'(i)) begin
          tbl[i] <= {2'b10, pwdata_i[l2fa_pkg::ACC_DIRECT], acc_mac, acc_vid,
                     pwdata_i[11:0], 4'(l2fa_pkg::CPU_PORT)};
        end
        if (cpu_entry_remove_cmd_go && cpu_res[3:0] == 4'(i)) begin
          tbl[i].valid <= 1'b0;
        end
      end
    end
  end

  logic [3:0] src_q;
  logic [3:0] clr_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_q <= 4'h0;
      clr_q <= 4'h0;
    end else begin
      src_q <= fr.src_port;
      clr_q <= s_res[3:0];
    end
  end

  sequence s_scan_step;
    state == ST_SCAN && scan_idx != 4'hF;
  endsequence
  property p_scan_walk;
    @(posedge clock_i) disable iff (!arst_n_i)
    s_scan_step |=> state == ST_SCAN && scan_idx == $past(scan_idx) + 4'h1;
  endproperty
  a_scan_walk: assert property (p_scan_walk) else $error("scan skipped an entry");
  property p_scan_start;
    @(posedge clock_i) disable iff (!arst_n_i)
    cmd_age_go |=> state == ST_SCAN && scan_idx == 4'h0 ##15 state == ST_SCAN ##1 state == ST_IDLE;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("age command scan wrong");
  property p_auto_start;
    @(posedge clock_i) disable iff (!arst_n_i)
    auto_due |-> ##[1:17] state == ST_SCAN;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto scan not started");
  property p_no_echo;
    @(posedge clock_i) disable iff (!arst_n_i)
    fr.valid && fr.src_port < 4'(l2fa_pkg::CPU_PORT) |=> !dec_o.dest_mask[src_q];
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("frame sent back to ingress");
  property p_rx_off;
    @(posedge clock_i) disable iff (!arst_n_i)
    fr.valid && !rx_ok |=> dec_o.valid && dec_o.dest_mask == 12'h000;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("disabled port forwarded");
  property p_redirect;
    @(posedge clock_i) disable iff (!arst_n_i)
    lrn_redir && grant |=> dec_o.dest_mask == l2fa_pkg::CPU_BIT && dec_o.to_cpu;
  endproperty
  a_redirect: assert property (p_redirect) else $error("redirect not CPU only");
  property p_discard;
    @(posedge clock_i) disable iff (!arst_n_i)
    lrn_discard |=> dec_o.dest_mask == 12'h000;
  endproperty
  a_discard: assert property (p_discard) else $error("learn frame not dropped");
  property p_age_clr;
    @(posedge clock_i) disable iff (!arst_n_i)
    age_clr && !cmd_go |=> tbl[clr_q].valid && !tbl[clr_q].age;
  endproperty
  a_age_clr: assert property (p_age_clr) else $error("age bit not cleared");
  property p_entry_remove_cmd;
    @(posedge clock_i) disable iff (!arst_n_i)
    cpu_entry_remove_cmd_go |=> !cpu_res[4];
  endproperty
  a_entry_remove_cmd: assert property (p_entry_remove_cmd) else $error("entry_remove_cmd left the entry");
  property p_uc_entry;
    @(posedge clock_i) disable iff (!arst_n_i)
    pgt[l2fa_pkg::CPU_PORT] == l2fa_pkg::CPU_BIT && pgt[0] == l2fa_pkg::ONE_PORT;
  endproperty
  a_uc_entry: assert property (p_uc_entry) else $error("unicast entry changed");
endmodule

// ===== l2fa_pkg.sv
package l2fa_pkg;
// Notes on behaviour
// - Known unicast goes to its one port
// - Broadcast and unknown flood except ingress
// - Seven flood masks per frame type
// - Port group table 92; 0-63 destinations
// - Entries 0-11 hold only own port
// - Aggregation masks 64-79 pick one member
// - Source masks 80-91 remove ingress port
// - Direct-encoded entries bypass destination masks
// - Receive on after reset, per-port disable
// - Table keyed by address plus VID
// - Hardware learning inserts unknown sources itself
// - CPU learning copies and still forwards
// - Secure learning redirects to CPU only
// - No learning discards learn frames
// - Learn frames to CPU are policed
// - Scan sets clear age, removes set
// - Source hit clears the age bit
// - Automatic scans at programmed second interval
// - CPU command starts one age scan
// - Scan filter by port, VLAN or both
// - Entry_remove_cmd command removes one entry
  localparam int NPORT = 12;
  localparam int CPU_PORT = 11;
  localparam int PGT_N = 92;
  localparam int PGT_UC_N = 12;
  localparam int PGT_AGGR = 64;
  localparam int PGT_SRC = 80;
  localparam int MAC_N = 16;
  localparam int NFLOOD = 7;
  localparam logic [11:0] CPU_BIT = 12'h800;
  localparam logic [11:0] ALL_PORTS = 12'hFFF;
  localparam logic [11:0] ONE_PORT = 12'h001;
  localparam logic [47:0] BCAST_MAC = 48'hFFFF_FFFF_FFFF;
  localparam logic [11:0] OFF_AGE_INT = 12'h000;
  localparam logic [11:0] OFF_MAC_LO = 12'h004;
  localparam logic [11:0] OFF_MAC_HI = 12'h008;
  localparam logic [11:0] OFF_MAC_ACC = 12'h00C;
  localparam logic [11:0] OFF_AGE_FILT = 12'h010;
  localparam logic [11:0] OFF_STORM = 12'h014;
  localparam logic [11:0] OFF_FLOOD = 12'h020;
  localparam logic [11:0] OFF_FLOOD_END = 12'h03C;
  localparam logic [11:0] OFF_PCFG = 12'h040;
  localparam logic [11:0] OFF_PCFG_END = 12'h070;
  localparam logic [11:0] OFF_PGT = 12'h100;
  localparam logic [11:0] OFF_PGT_END = 12'h270;
  localparam int PCFG_RECV = 0;
  localparam int PCFG_LEARN = 1;
  localparam int PCFG_CPU = 2;
  localparam int PCFG_DROP = 3;
  localparam int PCFG_AUTO = 4;
  localparam int PCFG_CPUQ = 5;
  localparam int ACC_DIRECT = 12;
  localparam int ACC_CMD = 16;
  localparam int ACC_BUSY = 31;
  localparam int FILT_PORT_EN = 4;
  localparam int FILT_VID = 16;
  localparam int FILT_VID_EN = 28;
  localparam logic [7:0] PCFG_RESET = 8'h01;
  localparam logic [19:0] AGE_INT_RESET = 20'h00000;
  localparam logic [15:0] STORM_RESET = 16'h0064;
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int AGE_STEP_S = 1;
  localparam int SEC_CYCLES = AGE_STEP_S * CLK_FREQ_HZ;
  typedef enum logic [1:0] {CMD_IDLE, CMD_LEARN, CMD_ENTRY_REMOVE_CMD, CMD_AGE} l2fa_cmd_e;
  typedef enum logic [2:0] {
    FT_UC, FT_L2MC, FT_BC, FT_IP4_DATA, FT_IP4_CTRL, FT_IP6_DATA, FT_IP6_CTRL
  } l2fa_ftype_e;
  typedef struct packed {
    logic valid;
    logic [3:0] src_port;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [11:0] vid;
    l2fa_ftype_e ftype;
    logic [3:0] aggr_hash;
  } l2fa_frame_s;
  typedef struct packed {
    logic valid;
    logic [11:0] dest_mask;
    logic to_cpu;
    logic [2:0] cpu_queue;
  } l2fa_dec_s;
  typedef struct packed {
    logic valid;
    logic age;
    logic direct;
    logic [47:0] mac;
    logic [11:0] vid;
    logic [11:0] dest;
    logic [3:0] port;
  } l2fa_entry_s;
endpackage

// ===== l2fa_policer.sv
`timescale 1ns/10ps
module l2fa_policer (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic sec_tick_i,
  input wire logic [15:0] limit_i,
  input wire logic req_i,
  output logic grant_o
);
  logic [15:0] count;

  assign grant_o = req_i && (count < limit_i);

  // Window restarts each second; a grant in the tick cycle counts in the new window
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= 16'h0000;
    end else if (sec_tick_i) begin
      count <= grant_o ? 16'h0001 : 16'h0000;
    end else if (grant_o) begin
      count <= count + 16'h0001;
    end
  end
endmodule

// ===== l2fa_port_model.sv
`timescale 1ns/10ps
module l2fa_port_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire l2fa_pkg::l2fa_frame_s req_i,
  output l2fa_pkg::l2fa_frame_s frame_o
);
  l2fa_pkg::l2fa_frame_s idle;
  // Idle fields toggle so stale header bits never look like a frame
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) idle <= '0;
    else idle <= ~idle;
  end
  assign frame_o = req_i.valid ? req_i : {1'b0, idle[$bits(idle)-2:0]};
endmodule

// ===== test_l2_forward_learn_age.sv
`timescale 1ns/10ps
module test_l2_forward_learn_age;
  logic clock_i, arst_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, vid;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [2:0] cq;
  l2fa_pkg::l2fa_frame_s req, frame;
  l2fa_pkg::l2fa_dec_s dec;
  int fail_count, check_count;
  logic [11:0] pgt [92];
  logic [11:0] flood [7];
  logic [47:0] mac_a, mac_b;
  l2fa_core #(.SEC_CYCLES(500)) uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .frame_i(frame), .dec_o(dec));
  l2fa_port_model ports (.clock_i(clock_i), .arst_n_i(arst_n_i), .req_i(req), .frame_o(frame));
  initial begin
    clock_i = 0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle edge so the next setup never reassigns psel in this time step
    @(posedge clock_i);
  endtask
  task automatic rchk(string w, logic [11:0] a, logic [31:0] e);
    apb(0, a, 0);
    check(w, rd, e);
  endtask
  // Polls busy so a scan never overlaps the next command
  task automatic mac(logic [1:0] cmd, logic [47:0] m, logic [12:0] dst);
    apb(1, 12'h004, m[31:0]);
    apb(1, 12'h008, {4'h0, vid, m[47:32]});
    apb(1, 12'h00C, {14'h0, cmd, 3'h0, dst});
    do apb(0, 12'h00C, 0); while (rd[31] !== 1'b0);
  endtask
  function automatic logic [11:0] fw(logic [11:0] m, int src, int h);
    return m & pgt[64 + h] & pgt[80 + src];
  endfunction
  task automatic send(int src, logic [47:0] d, logic [47:0] s, int ft, int h, logic [11:0] e);
    req <= '{1'b1, 4'(src), d, s, vid, l2fa_pkg::l2fa_ftype_e'(ft), 4'(h)};
    @(posedge clock_i);
    req.valid <= 1'b0;
    #1 check("dec", 32'({dec.valid, dec.to_cpu, dec.cpu_queue, dec.dest_mask}), {15'h0, 1'b1, e[11], cq, e});
    @(posedge clock_i);
  endtask
  initial begin
    seed = 32'h4E48;
    {psel, penable, pwrite, paddr, pwdata, req, vid, cq} = '0;
    vid = 12'h00A;
    fail_count = 0;
    check_count = 0;
    arst_n_i = 0;
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1;
    for (int i = 0; i < 92; i++)
      pgt[i] = i < 12 ? 12'(1 << i) : i < 64 ? 12'h0 : i < 80 ? 12'hFFF : ~12'(1 << (i - 80));
    for (int p = 0; p < 12; p++) begin
      rchk("port_cfg", 12'h040 + 12'(4 * p), 32'h1);
      rchk("pgt_uc", 12'h100 + 12'(4 * p), 32'(pgt[p]));
    end
    apb(1, 12'h10C, 32'h0);
    rchk("pgt_uc_wr", 12'h10C, 32'h8);
    apb(0, 12'h300, 0);
    check("slverr", 32'(err), 32'h1);
    send(3, 48'hFFFF_FFFF_FFFF, 48'h1, 2, 0, fw(12'hFFF, 3, 0));
    for (int k = 0; k < 7; k++) begin
      flood[k] = 12'($random(seed));
      apb(1, 12'h020 + 12'(4 * k), 32'(flood[k]));
      send(k + 1, 48'h0200_0000_0000 + k, 48'h1, k, 0, fw(flood[k], k + 1, 0));
    end
    pgt[12] = 12'($random(seed));
    apb(1, 12'h130, 32'(pgt[12]));
    mac_a = 48'h0100_5E00_0001;
    mac(1, mac_a, 13'h00C);
    send(2, mac_a, 48'h1, 1, 0, fw(pgt[12], 2, 0));
    vid = 12'h00B;
    send(2, mac_a, 48'h1, 1, 0, fw(flood[1], 2, 0));
    vid = 12'h00A;
    mac(1, mac_a, 13'h10A5);
    send(2, mac_a, 48'h1, 3, 0, fw(12'h0A5, 2, 0));
    pgt[69] = 12'hFFD;
    apb(1, 12'h214, 32'hFFD);
    send(2, mac_a, 48'h1, 3, 5, fw(12'h0A5, 2, 5));
    mac(2, mac_a, 0);
    send(2, mac_a, 48'h1, 3, 0, fw(flood[3], 2, 0));
    apb(1, 12'h064, 32'h0);
    send(9, 48'hFFFF_FFFF_FFFF, 48'h1, 2, 0, 12'h000);
    mac_a = 48'({$random(seed), $random(seed)});
    mac_b = 48'({$random(seed), $random(seed)});
    apb(1, 12'h050, 32'h13);
    apb(1, 12'h058, 32'h13);
    send(4, 48'hFFFF_FFFF_FFFF, mac_a, 2, 0, fw(flood[2], 4, 0));
    send(6, 48'hFFFF_FFFF_FFFF, mac_b, 2, 0, fw(flood[2], 6, 0));
    send(5, mac_a, 48'h1, 0, 0, fw(12'h010, 5, 0));
    apb(1, 12'h010, 32'h16);
    mac(3, 0, 0);
    mac(3, 0, 0);
    send(5, mac_a, 48'h1, 0, 0, fw(12'h010, 5, 0));
    send(5, mac_b, 48'h1, 0, 0, fw(flood[0], 5, 0));
    apb(1, 12'h010, 32'h0);
    mac(3, 0, 0);
    send(4, 48'hFFFF_FFFF_FFFF, mac_a, 2, 0, fw(flood[2], 4, 0));
    mac(3, 0, 0);
    send(5, mac_a, 48'h1, 0, 0, fw(12'h010, 5, 0));
    cq = 3'h5;
    apb(1, 12'h05C, 32'hA7);
    send(7, mac_a, 48'h9, 0, 0, 12'h810);
    apb(1, 12'h05C, 32'hAF);
    send(7, mac_a, 48'hA, 0, 0, 12'h800);
    apb(1, 12'h05C, 32'hAB);
    cq = 3'h0;
    send(7, mac_a, 48'hB, 0, 0, 12'h000);
    cq = 3'h5;
    apb(1, 12'h014, 32'h0);
    apb(1, 12'h05C, 32'hAF);
    send(7, mac_a, 48'hC, 0, 0, 12'h000);
    cq = 3'h0;
    apb(1, 12'h000, 32'h1);
    repeat (1600) @(posedge clock_i);
    apb(1, 12'h000, 32'h0);
    send(5, mac_a, 48'h1, 0, 0, fw(flood[0], 5, 0));
    report_and_stop();
  end
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule
